// ===== csh_params.svh
/*
 Constants of the clock-stop and halt controller: instruction operand,
 reset values, pin levels and restart timing.
 Assumes a 125 MHz always-on control clock.
*/
`ifndef CSH_PARAMS_SVH
`define CSH_PARAMS_SVH

`define CSH_CLK_MHZ 125
`define CSH_STOP_OPERAND 4'h0
`define CSH_PC_RESET 12'h000
`define CSH_CE_RESTART_MS 50
`define CSH_TCARRY_DEFAULT_MS 100
// Scaled so that no intermediate product leaves the 32-bit range
`define CSH_CE_RESTART_CYC (`CSH_CE_RESTART_MS * `CSH_CLK_MHZ * 1000)
`define CSH_GPIO_W 15
`define CSH_GPO_W 4
`define CSH_KEY_W 4
`define CSH_OSD_W 4
`define CSH_PWM_W 3
`define CSH_CRYSTAL_OUTPUT_STOP_LVL 1'b1
`define CSH_PWM_STOP_LVL 3'h0
`define CSH_OSD_STOP_LVL 4'h0

`endif

// ===== csh_pkg.sv
/*
 Types of the clock-stop and halt controller.
 Widths come from csh_params.svh.
*/
`include "csh_params.svh"

package csh_pkg;

   typedef enum logic [1:0] {
      CSH_RUN,
      CSH_HALT,
      CSH_STOP,
      CSH_WAKE
   } csh_state_t;

   typedef enum logic [1:0] {
      CSH_PIN_NORMAL,
      CSH_PIN_HALT,
      CSH_PIN_STOP
   } csh_pin_mode_t;

   typedef struct packed {
      logic [`CSH_GPIO_W-1:0] gpio_do;
      logic [`CSH_GPIO_W-1:0] gpio_oe;
      logic [`CSH_GPO_W-1:0] gpo;
      logic [`CSH_OSD_W-1:0] osd;
      logic [`CSH_OSD_W-1:0] osd_oe;
      logic [`CSH_PWM_W-1:0] pwm;
      logic dedicated_analog_input_oe;
   } csh_pins_t;

   typedef struct packed {
      logic xin_pulldown;
      logic crystal_output;
      logic [`CSH_KEY_W-1:0] key_pulldown;
   } csh_static_t;

endpackage

// ===== csh_pin_ctl.sv
/*
 Pin state control for halt and clock stop.
 Assumes the core drives normal pin values every cycle; the mode comes
 from csh_ctrl. All outputs are registered.
*/
`timescale 1ns/1ns
`default_nettype none
`include "csh_params.svh"

module csh_pin_ctl
   import csh_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Mode and core-side values
   input wire csh_pin_mode_t mode_i,
   input wire csh_pins_t core_pins_i,
   input wire logic [`CSH_KEY_W-1:0] key_adc_sel_i,
   // Pad side
   output csh_pins_t pins_o,
   output csh_static_t static_o
);

   csh_pins_t pins_d;
   csh_pins_t pins_q;
   csh_static_t static_d;
   csh_static_t static_q;

   wire logic is_halt = (mode_i == CSH_PIN_HALT);
   wire logic is_stop = (mode_i == CSH_PIN_STOP);

   always_comb
   begin
      pins_d = core_pins_i;
      if (is_halt)
      begin
         pins_d.osd = pins_q.osd;
         pins_d.osd_oe = pins_q.osd_oe;
         pins_d.dedicated_analog_input_oe = 1'b0;
      end
      else if (is_stop)
      begin
         pins_d.gpio_oe = '0;
         pins_d.gpio_do = '0;
         pins_d.gpo = pins_q.gpo;
         pins_d.osd = `CSH_OSD_STOP_LVL;
         pins_d.osd_oe = '0;
         pins_d.pwm = `CSH_PWM_STOP_LVL;
         pins_d.dedicated_analog_input_oe = 1'b0;
      end
   end

   // Pull-down is dropped only on the pin routed to the converter
   always_comb
   begin
      static_d.key_pulldown = ~key_adc_sel_i;
      static_d.xin_pulldown = is_stop;
      static_d.crystal_output = is_stop ? `CSH_CRYSTAL_OUTPUT_STOP_LVL : 1'b0;
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         pins_q <= '0;
         static_q <= '0;
      end
      else
      begin
         pins_q <= pins_d;
         static_q <= static_d;
      end
   end

   assign pins_o = pins_q;
   assign static_o = static_q;

endmodule

`default_nettype wire

// ===== csh_ctrl.sv
/*
 Clock-stop and halt controller of a 4-bit tuning controller core.
 Holds the low-power state, gates the crystal oscillator, issues core
 resets and drives the pin states through csh_pin_ctl.
 Assumes mclk_i is an always-on control clock, that the chip-enable pin,
 the power-on event and the timer-carry pulse are synchronous to it, and
 that the core presents one-cycle strobes for each executed STOP/HALT.
*/
`timescale 1ns/1ns
`default_nettype none
`include "csh_params.svh"

module csh_ctrl
   import csh_pkg::*;
#(
   parameter int unsigned RESTART_CYC = `CSH_CE_RESTART_CYC
)
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Instruction strobes from the core
   input wire logic stop_exec_i,
   input wire logic [3:0] stop_operand_i,
   input wire logic halt_exec_i,
   input wire logic halt_release_i,
   // System events
   input wire logic chip_enable_i,
   input wire logic por_i,
   input wire logic tcarry_set_i,
   // Core-side pin values
   input wire csh_pins_t core_pins_i,
   input wire logic [`CSH_KEY_W-1:0] key_adc_sel_i,
   // Core and peripheral control
   output logic osc_en_o,
   output logic core_rst_o,
   output logic pc_force_o,
   output logic [11:0] pc_force_val_o,
   output logic cpu_halt_o,
   output logic periph_stop_o,
   output logic ctrl_reg_init_o,
   output logic sys_reg_init_o,
   output logic stop_nop_o,
   output logic pfd_en_o,
   output logic [1:0] state_o,
   // Pads
   output csh_pins_t pins_o,
   output csh_static_t static_o
);

   csh_state_t state_q;
   csh_state_t state_d;
   logic ce_q;
   logic ce_pend_q;
   logic ce_pend_d;
   logic pfd_en_q;
   logic pfd_en_d;
   logic [31:0] wait_q;
   logic [31:0] wait_d;
   logic init_q;
   logic nop_q;
   logic restart_q;
   logic restart_d;
   csh_pin_mode_t pin_mode;

   function automatic logic op_is_stop(input logic [3:0] op);
      op_is_stop = (op == `CSH_STOP_OPERAND);
   endfunction

   wire logic ce_rise = chip_enable_i & ~ce_q;
   wire logic stop_ok = stop_exec_i & op_is_stop(stop_operand_i);
   wire logic stop_go = stop_ok & ~chip_enable_i;
   wire logic stop_nop = stop_ok & chip_enable_i;
   wire logic wait_done = (wait_q >= (RESTART_CYC - 32'h1));
   // Outside clock stop an enable edge resets at the next carry pulse
   wire logic ce_reset_now = ce_pend_q & tcarry_set_i;

   always_comb
   begin
      state_d = state_q;
      wait_d = wait_q;
      ce_pend_d = ce_pend_q;
      pfd_en_d = pfd_en_q;
      restart_d = 1'b0;
      case (state_q)
         CSH_RUN:
         begin
            if (ce_rise)
               ce_pend_d = 1'b1;
            if (stop_go)
            begin
               state_d = CSH_STOP;
               pfd_en_d = 1'b0;
               ce_pend_d = 1'b0;
            end
            else if (ce_reset_now)
            begin
               ce_pend_d = 1'b0;
               restart_d = 1'b1;
            end
            else if (halt_exec_i)
               state_d = CSH_HALT;
         end
         CSH_HALT:
         begin
            if (ce_rise)
               ce_pend_d = 1'b1;
            if (ce_reset_now)
            begin
               ce_pend_d = 1'b0;
               restart_d = 1'b1;
               state_d = CSH_RUN;
            end
            else if (halt_release_i)
               state_d = CSH_RUN;
         end
         CSH_STOP:
         begin
            if (ce_rise)
            begin
               state_d = CSH_WAKE;
               wait_d = '0;
            end
         end
         CSH_WAKE:
         begin
            wait_d = wait_q + 32'h1;
            if (wait_done)
            begin
               state_d = CSH_RUN;
               restart_d = 1'b1;
            end
         end
         default:
            state_d = CSH_RUN;
      endcase
      // Power-on reset overrides everything and re-arms the detector
      if (por_i)
      begin
         state_d = (state_q == CSH_RUN || state_q == CSH_HALT) ?
            CSH_RUN : CSH_WAKE;
         wait_d = '0;
         ce_pend_d = 1'b0;
         pfd_en_d = 1'b1;
         restart_d = (state_q == CSH_RUN || state_q == CSH_HALT);
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         state_q <= CSH_RUN;
         ce_q <= 1'b0;
         ce_pend_q <= 1'b0;
         pfd_en_q <= 1'b1;
         wait_q <= '0;
         init_q <= 1'b0;
         nop_q <= 1'b0;
         restart_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         ce_q <= chip_enable_i;
         ce_pend_q <= ce_pend_d;
         pfd_en_q <= pfd_en_d;
         wait_q <= wait_d;
         init_q <= stop_go & (state_q == CSH_RUN) & ~por_i;
         nop_q <= stop_nop & (state_q == CSH_RUN);
         restart_q <= restart_d;
      end
   end

   wire logic in_stop = (state_q == CSH_STOP);
   wire logic in_wake = (state_q == CSH_WAKE);

   // Wake holds the oscillator on but the core in reset until settled
   assign osc_en_o = ~in_stop;
   assign core_rst_o = in_stop | in_wake | restart_q;
   assign pc_force_o = in_stop | in_wake | restart_q;
   assign pc_force_val_o = `CSH_PC_RESET;
   assign cpu_halt_o = (state_q == CSH_HALT);
   assign periph_stop_o = in_stop | in_wake;
   assign ctrl_reg_init_o = init_q;
   assign sys_reg_init_o = init_q | restart_q;
   assign stop_nop_o = nop_q;
   assign pfd_en_o = pfd_en_q;
   assign state_o = state_q;

   assign pin_mode = (in_stop | in_wake) ? CSH_PIN_STOP :
      (state_q == CSH_HALT) ? CSH_PIN_HALT : CSH_PIN_NORMAL;

   csh_pin_ctl u_pin_ctl (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .mode_i(pin_mode),
      .core_pins_i(core_pins_i),
      .key_adc_sel_i(key_adc_sel_i),
      .pins_o(pins_o),
      .static_o(static_o)
   );

endmodule

`default_nettype wire

// ===== csh_ctrl_asserts.sv
/*
 Port checks of csh_ctrl, bound from the bench.
 Assumes RESTART_CYC is at least 8.
*/
`timescale 1ns/1ns
`default_nettype none
`include "csh_params.svh"

module csh_ctrl_asserts
   import csh_pkg::*;
#(
   parameter int unsigned RESTART_CYC = 20
)
(
   // Clock, reset and strobes
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic stop_exec_i,
   input wire logic [3:0] stop_operand_i,
   input wire logic halt_exec_i,
   input wire logic chip_enable_i,
   input wire logic por_i,
   input wire logic [`CSH_KEY_W-1:0] key_adc_sel_i,
   // Observed outputs
   input wire logic osc_en_o,
   input wire logic core_rst_o,
   input wire logic cpu_halt_o,
   input wire logic periph_stop_o,
   input wire logic ctrl_reg_init_o,
   input wire logic stop_nop_o,
   input wire logic pfd_en_o,
   input wire logic [1:0] state_o,
   input wire csh_pins_t pins_o,
   input wire csh_static_t static_o
);
   localparam int WLO = RESTART_CYC - 7;
   localparam int WHI = RESTART_CYC - 6;
   wire logic run_stop = state_o == 2'h0 && stop_exec_i && !por_i;
   wire logic op_zero = stop_operand_i == 4'h0;

   default clocking dclk @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   sequence wake_hold_s;
      (state_o == 2'h3 && core_rst_o) [*8];
   endsequence
   sequence restart_s;
      state_o == 2'h0 && core_rst_o ##1 !core_rst_o;
   endsequence
   sequence in_stop_s;
      state_o == 2'h2 [*3];
   endsequence
   sequence in_halt_s;
      state_o == 2'h1 [*3];
   endsequence

   stop_valid_a: assert property (run_stop && op_zero && !chip_enable_i |=>
      state_o == 2'h2 && !osc_en_o && core_rst_o && ctrl_reg_init_o)
      else $error("valid stop not taken");
   stop_nop_a: assert property (run_stop && op_zero && chip_enable_i |=>
      stop_nop_o && state_o == 2'h0) else $error("stop nop wrong");
   bad_op_a: assert property (run_stop && !op_zero && !halt_exec_i |=>
      state_o == 2'h0 && !stop_nop_o) else $error("bad operand acted");
   ce_wake_a: assert property (state_o == 2'h2 && $rose(chip_enable_i)
      && !por_i |=> state_o == 2'h3 && osc_en_o) else $error("no ce wake");
   por_wake_a: assert property (state_o == 2'h2 && por_i |=>
      state_o == 2'h3 ##[0:1] pfd_en_o) else $error("no por wake");
   pfd_off_a: assert property (state_o == 2'h2 |-> !pfd_en_o)
      else $error("pfd on in stop");
   periph_a: assert property (state_o[1] |-> periph_stop_o && !cpu_halt_o)
      else $error("periph not stopped");
   stop_pins_a: assert property (in_stop_s |-> pins_o.gpio_oe == '0
      && pins_o.pwm == 3'h0 && pins_o.osd_oe == 4'h0 && !pins_o.dedicated_analog_input_oe
      && static_o.xin_pulldown && static_o.crystal_output && $stable(pins_o.gpo))
      else $error("stop pins wrong");
   wake_len_a: assert property ($rose(state_o == 2'h3) && !por_i |->
      wake_hold_s ##[WLO:WHI] restart_s) else $error("wake length wrong");
   halt_a: assert property (state_o == 2'h0 && halt_exec_i && !stop_exec_i
      && !por_i |=> state_o == 2'h1 && cpu_halt_o) else $error("no halt");
   halt_pins_a: assert property (in_halt_s |-> $stable(pins_o.osd)
      && !pins_o.dedicated_analog_input_oe) else $error("halt pins wrong");
   key_pull_a: assert property (!$past(rst_i) |->
      static_o.key_pulldown == ~$past(key_adc_sel_i))
      else $error("key pull wrong");
endmodule
`default_nettype wire

// ===== tb_top.sv
/*
 Self-checking bench of csh_ctrl with the port checker bound in.
 Assumes csh_pkg and the checker are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none
`include "csh_params.svh"

module tb_top
   import csh_pkg::*;
;
   // Short wake wait keeps the run brief
   localparam int RC = 20;
   logic mclk_i = 0, rst_i = 1, stop_exec_i = 0, halt_exec_i = 0;
   logic halt_release_i = 0, chip_enable_i = 1, por_i = 0, tcarry_set_i = 0;
   logic [3:0] stop_operand_i = 4'h0;
   logic [`CSH_KEY_W-1:0] key_adc_sel_i = 4'h0;
   csh_pins_t core_pins_i = '0;
   logic osc_en_o, core_rst_o, pc_force_o, cpu_halt_o, periph_stop_o;
   logic ctrl_reg_init_o, sys_reg_init_o, stop_nop_o, pfd_en_o;
   logic [11:0] pc_force_val_o;
   logic [1:0] state_o;
   csh_pins_t pins_o;
   csh_static_t static_o;
   int fails = 0, compares = 0, cyc_cnt = 0;

   csh_ctrl #(.RESTART_CYC(RC)) uut (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .stop_exec_i(stop_exec_i),
      .stop_operand_i(stop_operand_i),
      .halt_exec_i(halt_exec_i),
      .halt_release_i(halt_release_i),
      .chip_enable_i(chip_enable_i),
      .por_i(por_i),
      .tcarry_set_i(tcarry_set_i),
      .core_pins_i(core_pins_i),
      .key_adc_sel_i(key_adc_sel_i),
      .osc_en_o(osc_en_o),
      .core_rst_o(core_rst_o),
      .pc_force_o(pc_force_o),
      .pc_force_val_o(pc_force_val_o),
      .cpu_halt_o(cpu_halt_o),
      .periph_stop_o(periph_stop_o),
      .ctrl_reg_init_o(ctrl_reg_init_o),
      .sys_reg_init_o(sys_reg_init_o),
      .stop_nop_o(stop_nop_o),
      .pfd_en_o(pfd_en_o),
      .state_o(state_o),
      .pins_o(pins_o),
      .static_o(static_o)
   );

   initial
   begin
      forever #4 mclk_i = ~mclk_i;
   end

   task close_out;
      $display("fails %0d compares %0d", fails, compares);
      if (fails == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge mclk_i)
   begin
      cyc_cnt++;
      if (cyc_cnt == 2000)
      begin
         fails++;
         $display("Error %0t timeout", $time);
         close_out;
      end
   end

   task cyc(input int n);
      repeat (n) @(negedge mclk_i);
   endtask

   task ck(input logic bad, input string m);
      compares++;
      if (bad !== 1'b0)
      begin
         fails++;
         $display("Error %0t %s", $time, m);
      end
   endtask

   task stop_op(input logic [3:0] op);
      stop_operand_i = op;
      stop_exec_i = 1;
      cyc(1);
      stop_exec_i = 0;
   endtask

   task wake_run;
      int n;
      n = 0;
      while (state_o !== 2'h0 && n < 100)
      begin
         cyc(1);
         n++;
      end
      ck(n < RC || n > RC + 1, "wake length");
      ck(core_rst_o !== 1'b1, "restart hold");
      cyc(1);
      ck(core_rst_o !== 1'b0, "restart end");
   endtask

   task t_simple;
      key_adc_sel_i = 4'h4;
      stop_op(4'h0);
      ck(stop_nop_o !== 1'b1 || state_o !== 2'h0, "nop");
      ck(static_o.key_pulldown !== 4'hB, "key pull");
      // Program spins on its branch-to-self; enable edge is pending
      tcarry_set_i = 1;
      cyc(1);
      tcarry_set_i = 0;
      ck(core_rst_o !== 1'b1 || sys_reg_init_o !== 1'b1, "ce reset");
      cyc(1);
      ck(core_rst_o !== 1'b0 || state_o !== 2'h0, "ce reset end");
      chip_enable_i = 0;
      stop_op(4'h1);
      ck(state_o !== 2'h0 || stop_nop_o !== 1'b0, "operand");
   endtask

   task t_halt;
      core_pins_i.osd = 4'h9;
      core_pins_i.dedicated_analog_input_oe = 1;
      cyc(2);
      halt_exec_i = 1;
      cyc(1);
      halt_exec_i = 0;
      ck(state_o !== 2'h1 || cpu_halt_o !== 1'b1, "halt entry");
      core_pins_i.osd = 4'h6;
      cyc(3);
      ck(pins_o.osd !== 4'h9 || pins_o.dedicated_analog_input_oe !== 1'b0, "halt pins");
      halt_release_i = 1;
      cyc(2);
      halt_release_i = 0;
      ck(state_o !== 2'h0, "halt exit");
   endtask

   task t_stop;
      core_pins_i = '1;
      core_pins_i.gpo = 4'hA;
      cyc(2);
      stop_op(4'h0);
      ck(state_o !== 2'h2 || osc_en_o !== 1'b0, "stop entry");
      ck(ctrl_reg_init_o !== 1'b1 || sys_reg_init_o !== 1'b1, "init");
      ck(pc_force_o !== 1'b1 || pc_force_val_o !== 12'h000, "pc");
      core_pins_i.gpo = 4'h5;
      cyc(2);
      ck(pins_o.gpo !== 4'hA, "gpo hold");
      ck(pins_o.gpio_oe !== 15'h0000 || pins_o.pwm !== 3'h0, "port");
      ck(pins_o.osd_oe !== 4'h0 || pins_o.dedicated_analog_input_oe !== 1'b0, "osd");
      ck(static_o.xin_pulldown !== 1'b1 || static_o.crystal_output !== 1'b1, "xtal");
      ck(periph_stop_o !== 1'b1 || pfd_en_o !== 1'b0, "periph");
      chip_enable_i = 1;
      cyc(1);
      ck(state_o !== 2'h3 || osc_en_o !== 1'b1, "ce wake");
      wake_run;
   endtask

   task t_por;
      chip_enable_i = 0;
      cyc(1);
      stop_op(4'h0);
      por_i = 1;
      cyc(1);
      por_i = 0;
      ck(state_o !== 2'h3, "por wake");
      ck(pfd_en_o !== 1'b1, "pfd on");
      wake_run;
   endtask

   initial
   begin
      repeat (12) @(negedge mclk_i);
      rst_i = 0;
      cyc(1);
      t_simple;
      t_halt;
      t_stop;
      t_por;
      close_out;
   end
endmodule

bind csh_ctrl csh_ctrl_asserts #(.RESTART_CYC(RESTART_CYC)) u_chk (
   .mclk_i(mclk_i),
   .rst_i(rst_i),
   .stop_exec_i(stop_exec_i),
   .stop_operand_i(stop_operand_i),
   .halt_exec_i(halt_exec_i),
   .chip_enable_i(chip_enable_i),
   .por_i(por_i),
   .key_adc_sel_i(key_adc_sel_i),
   .osc_en_o(osc_en_o),
   .core_rst_o(core_rst_o),
   .cpu_halt_o(cpu_halt_o),
   .periph_stop_o(periph_stop_o),
   .ctrl_reg_init_o(ctrl_reg_init_o),
   .stop_nop_o(stop_nop_o),
   .pfd_en_o(pfd_en_o),
   .state_o(state_o),
   .pins_o(pins_o),
   .static_o(static_o)
);
`default_nettype wire
